/* File: include/hb_pkg.sv */
package hb_pkg;
   localparam int NUM_BRIDGES = 4;
   // Register indices; the byte address is four times the index
   localparam logic [3:0] IDX_BRIDGE_OUT   = 4'h1;
   localparam logic [3:0] IDX_BRIDGE_STAT  = 4'h3;
   localparam logic [3:0] IDX_MUX_CTL      = 4'h8;
   localparam logic [3:0] IDX_SYS_CTL      = 4'h9;
   localparam logic [3:0] IDX_IRQ_FLAG     = 4'ha;
   localparam logic [3:0] IDX_IRQ_MASK     = 4'hb;
   // System control fields
   localparam int SYS_ENABLE_BIT  = 0;
   localparam int SYS_HOTSEL_LO   = 1;
   localparam int SYS_INHIBIT_BIT = 3;
   // Bridge status/control fields
   localparam int STAT_OCF_LO     = 0;
   localparam int STAT_RECIRC_BIT = 4;
   // Interrupt flag fields
   localparam int IRQ_HOT_BIT     = 0;
   localparam int IRQ_LV_BIT      = 1;
   localparam int IRQ_HV_BIT      = 2;
   // Mux control fields
   localparam int MUX_GAIN_BIT    = 4;
   localparam int MUX_SS_LO       = 0;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   // Break-before-make gate discharge time
   localparam int BBM_TIME_NS     = 100;
   localparam int CLK_PERIOD_NS   = 25;
   localparam int BBM_CYCLES      = (BBM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BBM_CNT_W       = 4;
   // Per-bridge gate state
   typedef enum logic [3:0] {
      GATE_OFF  = 4'b0001,
      GATE_HIGH = 4'b0010,
      GATE_LOW  = 4'b0100,
      GATE_WAIT = 4'b1000
   } gate_state_type;
endpackage

/* File: src/bridge_gate.sv */
`timescale 1ns/1ps
// One half-bridge: decode, protection gating and break-before-make
module bridge_gate #(
   parameter int BBM_CYCLES = hb_pkg::BBM_CYCLES
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic high_ctl,
   input  wire logic low_ctl,
   input  wire logic enable,
   input  wire logic recirc,
   input  wire logic pwm_sync,
   input  wire logic hs_block,
   input  wire logic ls_block,
   output logic      hs_gate_r,
   output logic      ls_gate_r
);
   initial begin
      if (BBM_CYCLES < 1 || BBM_CYCLES >= (1 << hb_pkg::BBM_CNT_W))
         $error("bridge_gate: BBM_CYCLES out of range");
   end

   logic                        want_hs;
   logic                        want_ls;
   logic [hb_pkg::BBM_CNT_W-1:0] cnt_r;
   hb_pkg::gate_state_type      state_r;
   logic                        target_hs_r;

   // Requested gate levels, before dead time
   always_comb begin
      want_hs = 1'b0;
      want_ls = 1'b0;
      if (enable) begin
         case ({high_ctl, low_ctl})
            2'b01:   want_ls = 1'b1;
            2'b10:   want_hs = 1'b1;
            2'b11: begin
               want_hs = pwm_sync;
               want_ls = recirc & ~pwm_sync;
            end
            default: ;
         endcase
      end
      if (hs_block) want_hs = 1'b0;
      if (ls_block) want_ls = 1'b0;
   end

   // Dead time between sides; turn-off is immediate, turn-on waits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r     <= hb_pkg::GATE_OFF;
         cnt_r       <= '0;
         target_hs_r <= 1'b0;
      end else begin
         case (state_r)
            hb_pkg::GATE_OFF: begin
               if (want_hs | want_ls) begin
                  state_r     <= hb_pkg::GATE_WAIT;
                  target_hs_r <= want_hs;
                  cnt_r       <= hb_pkg::BBM_CNT_W'(BBM_CYCLES - 1);
               end
            end
            hb_pkg::GATE_WAIT: begin
               if (want_hs != target_hs_r || !(want_hs | want_ls))
                  state_r <= hb_pkg::GATE_OFF;
               else if (cnt_r == '0)
                  state_r <= target_hs_r ? hb_pkg::GATE_HIGH : hb_pkg::GATE_LOW;
               else
                  cnt_r <= cnt_r - 1'b1;
            end
            hb_pkg::GATE_HIGH: if (!want_hs) state_r <= hb_pkg::GATE_OFF;
            hb_pkg::GATE_LOW:  if (!want_ls) state_r <= hb_pkg::GATE_OFF;
            default: state_r <= hb_pkg::GATE_OFF;
         endcase
      end
   end

   // Registered gates; blocks also cut the gate in the same edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_gate_r <= 1'b0;
         ls_gate_r <= 1'b0;
      end else begin
         hs_gate_r <= (state_r == hb_pkg::GATE_HIGH) & want_hs;
         ls_gate_r <= (state_r == hb_pkg::GATE_LOW) & want_ls;
      end
   end
endmodule // bridge_gate

/* File: src/half_bridge_gate_control.sv */
`timescale 1ns/1ps
// Quad half-bridge control with protection, APB register slave
module half_bridge_gate_control #(
   parameter int NUM_BRIDGES = hb_pkg::NUM_BRIDGES,
   parameter int BBM_CYCLES  = hb_pkg::BBM_CYCLES
) (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   input  wire logic [3:0]             pstrb,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   pwm_in,
   input  wire logic                   hot_warning,
   input  wire logic                   hot_hard_trip,
   input  wire logic                   undervolt_in,
   input  wire logic                   overvolt_in,
   input  wire logic [NUM_BRIDGES-1:0] hs_overcurrent,
   input  wire logic [NUM_BRIDGES-1:0] ls_overcurrent,
   output logic      [NUM_BRIDGES-1:0] hs_gate,
   output logic      [NUM_BRIDGES-1:0] ls_gate,
   output logic                        hot_irq,
   output logic                        stages_off,
   output logic                        sense_gain_select,
   output logic      [3:0]             mux_source
);
   // Register map is laid out for exactly four bridges
   initial begin
      if (NUM_BRIDGES != hb_pkg::NUM_BRIDGES)
         $error("half_bridge_gate_control: NUM_BRIDGES must be 4");
   end

   // Register state
   logic [7:0]             bridge_output_control_r;
   logic [NUM_BRIDGES-1:0] bridge_overcurrent_flag_r;
   logic                   recirc_select_r;
   logic                   power_stage_enable_r;
   logic [1:0]             hot_shutdown_sel_r;
   logic                   volt_shutdown_inhibit_r;
   logic                   hot_flag_r;
   logic                   undervolt_flag_r;
   logic                   overvolt_flag_r;
   logic                   hot_irq_mask_r;
   logic                   sense_gain_r;
   logic [3:0]             mux_ss_r;

   // Two-flop synchronisers for pins
   logic       pwm_m_r, pwm_s_r;
   logic [3:0] mon_m_r, mon_s_r;
   logic [NUM_BRIDGES-1:0] hoc_m_r, hoc_s_r, loc_m_r, loc_s_r;
   logic       hot_now, trip_now, uv_now, ov_now;

   // Only the second stage is read by logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_m_r <= 1'b0;
         pwm_s_r <= 1'b0;
         mon_m_r <= 4'h0;
         mon_s_r <= 4'h0;
         hoc_m_r <= '0;
         hoc_s_r <= '0;
         loc_m_r <= '0;
         loc_s_r <= '0;
      end else begin
         pwm_m_r <= pwm_in;
         pwm_s_r <= pwm_m_r;
         mon_m_r <= {overvolt_in, undervolt_in, hot_hard_trip, hot_warning};
         mon_s_r <= mon_m_r;
         hoc_m_r <= hs_overcurrent;
         hoc_s_r <= hoc_m_r;
         loc_m_r <= ls_overcurrent;
         loc_s_r <= loc_m_r;
      end
   end
   // Monitor bits in the order of the capture word
   assign hot_now  = mon_s_r[0];
   assign trip_now = mon_s_r[1];
   assign uv_now   = mon_s_r[2];
   assign ov_now   = mon_s_r[3];

   // APB decode; slave answers with zero wait states
   logic       wr_en;
   logic [3:0] idx;
   logic       idx_ok;
   logic       addr_ok;
   assign idx     = paddr[5:2];
   assign idx_ok  = (idx == hb_pkg::IDX_BRIDGE_OUT) || (idx == hb_pkg::IDX_BRIDGE_STAT) ||
                    (idx == hb_pkg::IDX_MUX_CTL) || (idx == hb_pkg::IDX_SYS_CTL) ||
                    (idx == hb_pkg::IDX_IRQ_FLAG) || (idx == hb_pkg::IDX_IRQ_MASK);
   assign addr_ok = idx_ok && (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0);
   // Writes land at the access edge, low byte lane only
   assign wr_en   = psel && penable && pwrite && addr_ok && pstrb[0];

   // Zero wait: pready and pslverr stand only in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
      end
   end

   // Write strobes, one per register
   logic                   wr_out, wr_stat, wr_mux, wr_sys, wr_flag, wr_mask;
   assign wr_out  = wr_en && (idx == hb_pkg::IDX_BRIDGE_OUT);
   assign wr_stat = wr_en && (idx == hb_pkg::IDX_BRIDGE_STAT);
   assign wr_mux  = wr_en && (idx == hb_pkg::IDX_MUX_CTL);
   assign wr_sys  = wr_en && (idx == hb_pkg::IDX_SYS_CTL);
   assign wr_flag = wr_en && (idx == hb_pkg::IDX_IRQ_FLAG);
   assign wr_mask = wr_en && (idx == hb_pkg::IDX_IRQ_MASK);

   // Plain control registers
   // Reserved bits are dropped on write and read back as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bridge_output_control_r <= hb_pkg::RST_BYTE;
         recirc_select_r         <= 1'b0;
         power_stage_enable_r    <= 1'b0;
         hot_shutdown_sel_r      <= 2'b00;
         volt_shutdown_inhibit_r <= 1'b0;
         hot_irq_mask_r          <= 1'b0;
         sense_gain_r            <= 1'b0;
         mux_ss_r                <= 4'h0;
      end else begin
         if (wr_out)  bridge_output_control_r <= pwdata[7:0];
         if (wr_stat) recirc_select_r <= pwdata[hb_pkg::STAT_RECIRC_BIT];
         if (wr_sys) begin
            power_stage_enable_r    <= pwdata[hb_pkg::SYS_ENABLE_BIT];
            hot_shutdown_sel_r      <= pwdata[hb_pkg::SYS_HOTSEL_LO +: 2];
            volt_shutdown_inhibit_r <= pwdata[hb_pkg::SYS_INHIBIT_BIT];
         end
         if (wr_mask) hot_irq_mask_r <= pwdata[hb_pkg::IRQ_HOT_BIT];
         if (wr_mux) begin
            sense_gain_r <= pwdata[hb_pkg::MUX_GAIN_BIT];
            mux_ss_r     <= pwdata[hb_pkg::MUX_SS_LO +: 4];
         end
      end
   end

   // Sticky flags: set wins over clear, clear ignored while cause present
   // A clear that meets the fault is lost; software must clear again
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hot_flag_r       <= 1'b0;
         undervolt_flag_r <= 1'b0;
         overvolt_flag_r  <= 1'b0;
      end else begin
         if (hot_now)
            hot_flag_r <= 1'b1;
         else if (wr_flag && pwdata[hb_pkg::IRQ_HOT_BIT])
            hot_flag_r <= 1'b0;
         if (uv_now)
            undervolt_flag_r <= 1'b1;
         else if (wr_flag && pwdata[hb_pkg::IRQ_LV_BIT])
            undervolt_flag_r <= 1'b0;
         if (ov_now)
            overvolt_flag_r <= 1'b1;
         else if (wr_flag && pwdata[hb_pkg::IRQ_HV_BIT])
            overvolt_flag_r <= 1'b0;
      end
   end

   // Overcurrent flags per bridge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bridge_overcurrent_flag_r <= '0;
      end else begin
         for (int b = 0; b < NUM_BRIDGES; b++) begin
            if (hoc_s_r[b] | loc_s_r[b])
               bridge_overcurrent_flag_r[b] <= 1'b1;
            else if (wr_stat && pwdata[hb_pkg::STAT_OCF_LO + b])
               bridge_overcurrent_flag_r[b] <= 1'b0;
         end
      end
   end

   // Shutdown conditions
   // Hot shutdown cuts high sides only; trip and supply faults cut both
   logic hot_off, trip_off, volt_off, all_off;
   assign hot_off  = hot_flag_r && (hot_shutdown_sel_r != 2'b00);
   assign trip_off = trip_now && (hot_shutdown_sel_r == 2'b00);
   assign volt_off = (undervolt_flag_r | overvolt_flag_r) && !volt_shutdown_inhibit_r;
   assign all_off  = trip_off | volt_off;

   // Overcurrent blocks only the side that tripped; flag holds it off
   // Side latch drops one cycle after its flag is cleared
   logic [NUM_BRIDGES-1:0] hs_oc_r, ls_oc_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_oc_r <= '0;
         ls_oc_r <= '0;
      end else begin
         for (int b = 0; b < NUM_BRIDGES; b++) begin
            if (hoc_s_r[b]) hs_oc_r[b] <= 1'b1;
            else if (!bridge_overcurrent_flag_r[b]) hs_oc_r[b] <= 1'b0;
            if (loc_s_r[b]) ls_oc_r[b] <= 1'b1;
            else if (!bridge_overcurrent_flag_r[b]) ls_oc_r[b] <= 1'b0;
         end
      end
   end

   // One gate driver per bridge
   // Raw synchronised comparator also blocks, saving a cycle of stress
   genvar g;
   generate
      for (g = 0; g < NUM_BRIDGES; g++) begin : gen_bridge
         bridge_gate #(
            .BBM_CYCLES (BBM_CYCLES)
         ) u_gate (
            .pclk      (pclk),
            .presetn   (presetn),
            .high_ctl  (bridge_output_control_r[2*g+1]),
            .low_ctl   (bridge_output_control_r[2*g]),
            .enable    (power_stage_enable_r),
            .recirc    (recirc_select_r),
            .pwm_sync  (pwm_s_r),
            .hs_block  (all_off | hot_off | hs_oc_r[g] | hoc_s_r[g]),
            .ls_block  (all_off | ls_oc_r[g] | loc_s_r[g]),
            .hs_gate_r (hs_gate[g]),
            .ls_gate_r (ls_gate[g])
         );
      end
   endgenerate

   // Registered status outputs
   // stages_off resets high because every gate is off in reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hot_irq           <= 1'b0;
         stages_off        <= 1'b1;
         sense_gain_select <= 1'b0;
         mux_source        <= 4'h0;
      end else begin
         hot_irq           <= hot_flag_r & hot_irq_mask_r;
         stages_off        <= all_off | hot_off | !power_stage_enable_r;
         sense_gain_select <= sense_gain_r;
         mux_source        <= mux_ss_r;
      end
   end

   // Read data, registered in setup phase
   // Unmapped or misaligned reads return zero
   logic [31:0] rd_nxt;
   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (idx)
         hb_pkg::IDX_BRIDGE_OUT:  rd_nxt[7:0] = bridge_output_control_r;
         hb_pkg::IDX_BRIDGE_STAT: begin
            rd_nxt[hb_pkg::STAT_OCF_LO +: 4] = bridge_overcurrent_flag_r;
            rd_nxt[hb_pkg::STAT_RECIRC_BIT]  = recirc_select_r;
         end
         hb_pkg::IDX_MUX_CTL: begin
            rd_nxt[hb_pkg::MUX_GAIN_BIT]    = sense_gain_r;
            rd_nxt[hb_pkg::MUX_SS_LO +: 4]  = mux_ss_r;
         end
         hb_pkg::IDX_SYS_CTL: begin
            rd_nxt[hb_pkg::SYS_ENABLE_BIT]     = power_stage_enable_r;
            rd_nxt[hb_pkg::SYS_HOTSEL_LO +: 2] = hot_shutdown_sel_r;
            rd_nxt[hb_pkg::SYS_INHIBIT_BIT]    = volt_shutdown_inhibit_r;
         end
         hb_pkg::IDX_IRQ_FLAG: begin
            rd_nxt[hb_pkg::IRQ_HOT_BIT] = hot_flag_r;
            rd_nxt[hb_pkg::IRQ_LV_BIT]  = undervolt_flag_r;
            rd_nxt[hb_pkg::IRQ_HV_BIT]  = overvolt_flag_r;
         end
         hb_pkg::IDX_IRQ_MASK: rd_nxt[hb_pkg::IRQ_HOT_BIT] = hot_irq_mask_r;
         default: rd_nxt = 32'h0000_0000;
      endcase
      if (!addr_ok) rd_nxt = 32'h0000_0000;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= rd_nxt;
   end
endmodule // half_bridge_gate_control

/* File: tb/hb_asserts.sv */
`timescale 1ns/1ps
// Port-level timing and protection checks for the gate controller
module hb_asserts #(
   parameter int NUM_BRIDGES = 4
) (
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [11:0]            paddr,
   input wire logic [31:0]            pwdata,
   input wire logic [3:0]             pstrb,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire logic                   hot_hard_trip,
   input wire logic [NUM_BRIDGES-1:0] hs_overcurrent,
   input wire logic [NUM_BRIDGES-1:0] ls_overcurrent,
   input wire logic [NUM_BRIDGES-1:0] hs_gate,
   input wire logic [NUM_BRIDGES-1:0] ls_gate,
   input wire logic                   hot_irq,
   input wire logic                   sense_gain_select,
   input wire logic [3:0]             mux_source
);
   logic       acc;
   logic       wr;
   logic [1:0] hsel_r;
   logic       mask_r;
   logic [4:0] mux_r;
   // Transfer completes at the access edge
   assign acc = psel && penable && pready;
   assign wr  = acc && pwrite && pstrb[0];
   // Shadow copies of the fields the checks depend on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hsel_r <= 2'h0;
         mask_r <= 1'b0;
         mux_r  <= 5'h00;
      end else if (wr) begin
         if (paddr == 12'h024) hsel_r <= pwdata[2:1];
         if (paddr == 12'h02c) mask_r <= pwdata[0];
         if (paddr == 12'h020) mux_r <= pwdata[4:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_no_shoot: assert property ((hs_gate & ls_gate) == '0)
      else $error("both gates of one bridge on");
   chk_bbm_high: assert property (((hs_gate & ~$past(hs_gate))
      & ($past(ls_gate) | $past(ls_gate, 2))) == '0) else $error("high gate without dead time");
   chk_bbm_low: assert property (((ls_gate & ~$past(ls_gate))
      & ($past(hs_gate) | $past(hs_gate, 2))) == '0) else $error("low gate without dead time");
   chk_pready_one: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready not a single access cycle");
   chk_addr_map: assert property (acc |-> pslverr == !(paddr inside
      {12'h004, 12'h00c, 12'h020, 12'h024, 12'h028, 12'h02c})) else $error("pslverr wrong");
   chk_power_stage_enable_off: assert property (wr && paddr == 12'h024 && !pwdata[0]
      |-> ##2 (hs_gate == '0 && ls_gate == '0)) else $error("gates on without enable");
   chk_hard_trip: assert property ((hot_hard_trip && hsel_r == 2'h0) [*3]
      |=> (hs_gate == '0 && ls_gate == '0)) else $error("hard trip left a gate on");
   chk_hs_oc: assert property ((hs_gate & $past(hs_overcurrent)
      & $past(hs_overcurrent, 2) & $past(hs_overcurrent, 3)) == '0) else $error("hs oc gate on");
   chk_ls_oc: assert property ((ls_gate & $past(ls_overcurrent)
      & $past(ls_overcurrent, 2) & $past(ls_overcurrent, 3)) == '0) else $error("ls oc gate on");
   chk_irq_mask: assert property (hot_irq |-> (mask_r || $past(mask_r)))
      else $error("hot interrupt while masked");
   chk_gain_mirror: assert property (wr && paddr == 12'h020
      |-> ##2 ({sense_gain_select, mux_source} == mux_r)) else $error("mux outputs wrong");
   cover property (wr && paddr == 12'h004 && pwdata[1:0] == 2'h3);
   cover property (hs_overcurrent != '0);
   cover property (acc && pslverr);
   cover property (hot_irq);
endmodule // hb_asserts

bind half_bridge_gate_control hb_asserts #(.NUM_BRIDGES(NUM_BRIDGES)) u_hb_asserts (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr,
   .hot_hard_trip, .hs_overcurrent, .ls_overcurrent, .hs_gate, .ls_gate, .hot_irq,
   .sense_gain_select, .mux_source);

/* File: tb/hb_load_model.sv */
`timescale 1ns/1ps
// Power transistors with loads; a shorted load trips only while conducting
module hb_load_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [3:0] hs_gate,
   input  wire logic [3:0] ls_gate,
   input  wire logic [3:0] hs_short,
   input  wire logic [3:0] ls_short,
   output logic      [3:0] hs_overcurrent,
   output logic      [3:0] ls_overcurrent
);
   // Comparator output one cycle after the current rises
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_overcurrent <= 4'h0;
         ls_overcurrent <= 4'h0;
      end else begin
         hs_overcurrent <= hs_gate & hs_short;
         ls_overcurrent <= ls_gate & ls_short;
      end
   end
endmodule // hb_load_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin samples_checked++; if ((sn) !== (ex)) begin fail_count++; \
   $display("MISMATCH %s exp %0h got %0h", nm, ex, sn); end end
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pwm_in;
   logic hot_warning, hot_hard_trip, undervolt_in, overvolt_in, hot_irq, stages_off, gain;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [3:0]  pstrb, hs_oc, ls_oc, hs_gate, ls_gate, mux_source, hs_short, ls_short;
   logic [3:0]  hblk, lblk;
   logic [7:0]  bo;
   logic [4:0]  mv;
   logic        power_stage_enable, recirc_select, erv;
   logic [11:0] map [6] = '{12'h004, 12'h00c, 12'h020, 12'h024, 12'h028, 12'h02c};
   int          fail_count, samples_checked, cyc;
   half_bridge_gate_control #(.BBM_CYCLES(2)) u_half_bridge_gate_control (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .pwm_in, .hot_warning, .hot_hard_trip, .undervolt_in, .overvolt_in,
      .hs_overcurrent(hs_oc), .ls_overcurrent(ls_oc), .hs_gate, .ls_gate, .hot_irq,
      .stages_off, .sense_gain_select(gain), .mux_source);
   hb_load_model u_hb_load_model (.pclk, .presetn, .hs_gate, .ls_gate, .hs_short,
      .ls_short, .hs_overcurrent(hs_oc), .ls_overcurrent(ls_oc));
   // 40 MHz clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // Hang guard, well above the expected run length
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 8000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // One APB transfer; only the hang guard ends the wait for pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, 4'hf};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Expected gates {hs, ls} from the table, recirculation and protection
   function automatic logic [7:0] mdl();
      logic [3:0] h, l;
      for (int b = 0; b < 4; b++) begin
         h[b] = bo[2*b+1] & (!bo[2*b] | pwm_in);
         l[b] = bo[2*b] & (!bo[2*b+1] | (recirc_select & !pwm_in));
      end
      return power_stage_enable ? {h & ~hblk, l & ~lblk} : 8'h00;
   endfunction
   // Sync, dead time and register stage all settle within this wait
   task automatic chk_gates();
      idle(12);
      `CHK("gates", mdl(), {hs_gate, ls_gate})
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0);
      `CHK("read", ex, rdv)
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, pwm_in} = '0;
      {hot_warning, hot_hard_trip, undervolt_in, overvolt_in, hs_short, ls_short} = '0;
      {bo, power_stage_enable, recirc_select, hblk, lblk} = '0;
      void'($urandom(7248));
      idle(10);
      presetn <= 1'b1;
      idle(1);
      `CHK("stages_off", 1'b1, stages_off)
      for (int i = 0; i < 6; i++) rd_chk(map[i], 32'h0);
      for (int i = 0; i < 2; i++) begin
         apb(1'b0, i ? 12'h040 : 12'h011, 32'h0);
         `CHK("slverr", 2'b10, {erv, |rdv})
      end
      // Control bits are dead while the stage enable is clear
      bo = 8'h5a;
      apb(1'b1, 12'h004, {24'h0, bo});
      chk_gates();
      power_stage_enable = 1'b1;
      apb(1'b1, 12'h024, 32'h1);
      // Every mode on every bridge, both recirculation settings, both PWM levels
      for (int i = 0; i < 16; i++) begin
         bo = (i < 4) ? 8'(i * 8'h55) : 8'($urandom);
         recirc_select = i[1];
         apb(1'b1, 12'h00c, {27'h0, recirc_select, 4'h0});
         apb(1'b1, 12'h004, {24'h0, bo});
         pwm_in <= i[0];
         chk_gates();
      end
      recirc_select = 1'b0;
      apb(1'b1, 12'h00c, 32'h0);
      // Short on bridge 0, high side then low side
      for (int s = 0; s < 2; s++) begin
         bo = s ? 8'h01 : 8'h02;
         apb(1'b1, 12'h004, {24'h0, bo});
         {hs_short[0], ls_short[0]} <= s ? 2'b01 : 2'b10;
         {hblk[0], lblk[0]} = s ? 2'b01 : 2'b10;
         chk_gates();
         {hs_short, ls_short} <= 8'h00;
         apb(1'b1, 12'h00c, 32'h0);
         rd_chk(12'h00c, 32'h1);
         chk_gates();
         apb(1'b1, 12'h00c, 32'h1);
         {hblk, lblk} = 8'h00;
         rd_chk(12'h00c, 32'h0);
         chk_gates();
      end
      // Warning temperature with shutdown selected and interrupt unmasked
      bo = 8'haa;
      apb(1'b1, 12'h004, {24'h0, bo});
      apb(1'b1, 12'h02c, 32'h1);
      apb(1'b1, 12'h024, 32'h3);
      hot_warning <= 1'b1;
      hblk = 4'hf;
      chk_gates();
      `CHK("hot_irq", 1'b1, hot_irq)
      apb(1'b1, 12'h028, 32'h1);
      rd_chk(12'h028, 32'h1);
      hot_warning <= 1'b0;
      idle(4);
      apb(1'b1, 12'h028, 32'h1);
      rd_chk(12'h028, 32'h0);
      hblk = 4'h0;
      chk_gates();
      `CHK("hot_irq", 1'b0, hot_irq)
      // Warning shutdown off: hard trip kills both sides
      apb(1'b1, 12'h024, 32'h1);
      bo = 8'h96;
      apb(1'b1, 12'h004, {24'h0, bo});
      hot_hard_trip <= 1'b1;
      {hblk, lblk} = 8'hff;
      chk_gates();
      `CHK("stages_off", 1'b1, stages_off)
      hot_hard_trip <= 1'b0;
      {hblk, lblk} = 8'h00;
      chk_gates();
      // Undervolt blocks; overvolt with inhibit set does not
      undervolt_in <= 1'b1;
      {hblk, lblk} = 8'hff;
      chk_gates();
      apb(1'b1, 12'h028, 32'h2);
      rd_chk(12'h028, 32'h2);
      undervolt_in <= 1'b0;
      idle(4);
      apb(1'b1, 12'h028, 32'h2);
      {hblk, lblk} = 8'h00;
      rd_chk(12'h028, 32'h0);
      apb(1'b1, 12'h024, 32'h9);
      overvolt_in <= 1'b1;
      chk_gates();
      overvolt_in <= 1'b0;
      // Gain select and mux source follow their fields
      for (int i = 0; i < 3; i++) begin
         mv = 5'($urandom);
         apb(1'b1, 12'h020, {27'h0, mv});
         idle(3);
         `CHK("mux", mv, {gain, mux_source})
      end
      // Clearing the stage enable drops live gates; masked hot raises no interrupt
      power_stage_enable = 1'b0;
      apb(1'b1, 12'h024, 32'h0);
      chk_gates();
      `CHK("stages_off", 1'b1, stages_off)
      apb(1'b1, 12'h02c, 32'h0);
      hot_warning <= 1'b1;
      idle(6);
      `CHK("hot_irq", 1'b0, hot_irq)
      rd_chk(12'h028, 32'h5);
      hot_warning <= 1'b0;
      conclude();
   end
endmodule // tb_top
